// ---- logic/cmos_params.svh ----
`ifndef CMOS_PARAMS_SVH
`define CMOS_PARAMS_SVH
// ----------------------------------------------------------------
// Register map and field positions
// ----------------------------------------------------------------
`define CMOS_ADDR_STATUS    8'hb2
`define CMOS_ADDR_TAG_HIGH  8'hbc
`define CMOS_ADDR_TAG_LOW   8'hbd
`define CMOS_ADDR_EXP_LEN   8'hb3
`define CMOS_NUM_OBJ        14
`define CMOS_BIT_LEN_WARN   7
`define CMOS_BIT_TX_DONE    6
`define CMOS_BIT_RX_DONE    5
`define CMOS_BIT_BIT_ERR    4
`define CMOS_BIT_STUFF_ERR  3
`define CMOS_BIT_CRC_ERR    2
`define CMOS_BIT_FORM_ERR   1
`define CMOS_BIT_ACK_ERR    0
`define CMOS_IRQ_MASK       8'h7f
`define CMOS_TAG_LOW_MASK   8'he0
`define CMOS_STATUS_RESET   8'h00
`endif

// ---- logic/cmos_pkg.sv ----
package cmos_pkg;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMOS_FLD_IDLE  = 3'h0,
    CMOS_FLD_ARB   = 3'h1,
    CMOS_FLD_CTRL  = 3'h2,
    CMOS_FLD_CRCD  = 3'h3,
    CMOS_FLD_ACK   = 3'h4,
    CMOS_FLD_ACKD  = 3'h5,
    CMOS_FLD_EOF   = 3'h6,
    CMOS_FLD_ERRF  = 3'h7
  } cmos_field_t;

  // One sampled bit time from the bit stream engine.
  typedef struct packed {
    logic        bit_valid;
    logic        tx_active;
    logic        tx_level;
    logic        rx_level;
    cmos_field_t field;
    logic        stuff_viol;
    logic        crc_bad;
  } cmos_bit_t;

  // End-of-frame report from the frame decoder.
  typedef struct packed {
    logic        rx_done;
    logic        tx_done;
    logic [13:0] rx_hits;
    logic [13:0] tx_pend;
    logic [3:0]  data_length_code;
    logic [10:0] ident;
  } cmos_frame_t;
endpackage : cmos_pkg

// ---- logic/cmos_status.sv ----
// Overview of operation
// R1: Successful reception into an enabled object sets its receive flag.
// R2: Multiple reception hits update the lowest index object first, 0 to 13.
// R3: Completion and error flags stay set until software clears them.
// R4: Bit errors are only detected while transmitting.
// R5: While sending, readback differing from driven level is a bit error.
// R6: Recessive sent, dominant read in arbitration is lost arbitration.
// R7: No bit error for dominant ack slot or during error frame.
// R8: Fixed-form field with wrong level sets the form error flag.
// R9: Fixed-form fields are CRC delimiter, ack delimiter and end of frame.
// R10: Transmitter reading no dominant ack slot sets ack error flag.
// R11: High tag byte holds identifier bits 10 to 3, MSB at bit 7.
// R12: Low tag byte bits 7 to 5 hold identifier bits 2 to 0.
// R13: Low tag bits 4 to 0 read arbitrary; software writes zeros there.
// R14: Stored length code updates on each received data or remote frame.
// R15: Received length code differing from programmed sets the warning flag.
// R16: Finished transmission sets transmit flag; lowest pending index first.
// R17: Six equal bits set stuff error; CRC mismatch sets CRC error.
// R18: Each set completion or error flag can raise an interrupt request.
`include "cmos_params.svh"

module cmos_status (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RESETN,
  input  wire logic [3:0]           PAGE_OBJ,
  input  wire logic [7:0]           SFR_ADDR,
  input  wire logic [7:0]           SFR_WDATA,
  input  wire logic                 SFR_WR,
  input  wire logic                 SFR_RD,
  input  wire cmos_pkg::cmos_bit_t   BIT_IN,
  input  wire cmos_pkg::cmos_frame_t FRAME_IN,
  output logic [7:0]                SFR_RDATA,
  output logic [3:0]                DLC_OUT,
  output logic                      IRQ
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  status_r [`CMOS_NUM_OBJ];
  logic [10:0] ident_r  [`CMOS_NUM_OBJ];
  logic [3:0]  dlc_r    [`CMOS_NUM_OBJ];
  logic [3:0]  cur_obj_r;
  logic [7:0]  rdata_r;
  logic [3:0]  dlc_out_r;
  logic        irq_r;
  logic        frame_tx_r;
  logic        bit_err_r;
  logic        ack_seen_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] lowest(input logic [13:0] v);
    logic [3:0] idx;
    idx = 4'hf;
    for (int i = `CMOS_NUM_OBJ - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : lowest

  function automatic logic field_is(input cmos_pkg::cmos_field_t fld,
                                    input cmos_pkg::cmos_field_t want);
    return fld == want;
  endfunction : field_is

  function automatic logic addr_is(input logic [7:0] addr,
                                   input logic [7:0] want);
    return addr == want;
  endfunction : addr_is

  wire cmos_pkg::cmos_bit_t   b = BIT_IN;
  wire cmos_pkg::cmos_frame_t f = FRAME_IN;

  // ----------------------------------------------------------------
  // Frame events
  // ----------------------------------------------------------------
  wire [3:0] rx_obj  = lowest(f.rx_hits);                      // see R2
  wire [3:0] tx_obj  = lowest(f.tx_pend);                      // see R16
  wire       rx_set  = f.rx_done && (rx_obj != 4'hf);          // see R1
  wire       tx_set  = f.tx_done && (tx_obj != 4'hf);          // see R16
  wire       aer_ev  = tx_set && !ack_seen_r;                  // see R10
  wire       lenw_ev = rx_set && (f.data_length_code != dlc_r[rx_obj]);     // see R15

  // ----------------------------------------------------------------
  // Bit monitor
  // ----------------------------------------------------------------
  wire       in_arb  = field_is(b.field, cmos_pkg::CMOS_FLD_ARB);
  wire       in_ack  = field_is(b.field, cmos_pkg::CMOS_FLD_ACK);
  wire       in_errf = field_is(b.field, cmos_pkg::CMOS_FLD_ERRF);
  wire       mism    = b.bit_valid && b.tx_active
                       && (b.tx_level != b.rx_level);          // see R4 R5
  // Recessive sent but dominant read while arbitrating means another
  // node won the bus, which is not a fault of this node.
  wire       arb_lost = in_arb && b.tx_level && !b.rx_level;   // see R6
  wire       exempt   = in_ack || in_errf;                     // see R7
  wire       ber_ev  = mism && !arb_lost && !exempt;           // see R5
  wire       fixed   = field_is(b.field, cmos_pkg::CMOS_FLD_CRCD)
                       || field_is(b.field, cmos_pkg::CMOS_FLD_ACKD)
                       || field_is(b.field, cmos_pkg::CMOS_FLD_EOF); // see R9
  wire       fer_ev  = b.bit_valid && fixed && !b.rx_level;    // see R8
  wire       ack_ev  = b.bit_valid && b.tx_active && in_ack
                       && !b.rx_level;                         // see R10
  wire       ser_ev  = b.bit_valid && b.stuff_viol;            // see R17
  wire       cer_ev  = b.bit_valid && b.crc_bad;               // see R17

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire       wr_stat = SFR_WR && addr_is(SFR_ADDR, `CMOS_ADDR_STATUS);
  wire       wr_high = SFR_WR && addr_is(SFR_ADDR, `CMOS_ADDR_TAG_HIGH);
  wire       wr_low  = SFR_WR && addr_is(SFR_ADDR, `CMOS_ADDR_TAG_LOW);
  // The control register itself lives outside this block; only the
  // expected length code carried by a write to it is kept here.
  wire       wr_dlc  = SFR_WR && addr_is(SFR_ADDR, `CMOS_ADDR_EXP_LEN);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire       rd_stat = addr_is(SFR_ADDR, `CMOS_ADDR_STATUS);
  wire       rd_high = addr_is(SFR_ADDR, `CMOS_ADDR_TAG_HIGH);
  wire       rd_low  = addr_is(SFR_ADDR, `CMOS_ADDR_TAG_LOW);
  // Unused low tag bits read as zero, one of the values allowed there.
  wire [7:0] tag_low = {ident_r[cur_obj_r][2:0], 5'h00};     // see R12 R13
  wire [7:0] rd_mux  = rd_stat ? status_r[cur_obj_r] :
                       rd_high ? ident_r[cur_obj_r][10:3] :  // see R11
                       rd_low  ? tag_low : 8'h00;

  // Error flags go to the lowest pending transmit object while sending, else to the paged object.
  wire [3:0] err_obj = frame_tx_r ? tx_obj : cur_obj_r;

  // ----------------------------------------------------------------
  // Per-object flags and tags
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `CMOS_NUM_OBJ; g++) begin : g_obj
    wire sel  = (cur_obj_r == 4'(g));
    wire erro = (err_obj == 4'(g));
    wire [7:0] ev;
    assign ev[`CMOS_BIT_LEN_WARN]  = lenw_ev && rx_obj == 4'(g); // see R15
    assign ev[`CMOS_BIT_TX_DONE]   = tx_set && tx_obj == 4'(g);  // see R16
    assign ev[`CMOS_BIT_RX_DONE]   = rx_set && rx_obj == 4'(g);  // see R1
    assign ev[`CMOS_BIT_BIT_ERR]   = erro && bit_err_r;          // see R4
    assign ev[`CMOS_BIT_STUFF_ERR] = erro && ser_ev;             // see R17
    assign ev[`CMOS_BIT_CRC_ERR]   = erro && cer_ev;             // see R17
    assign ev[`CMOS_BIT_FORM_ERR]  = erro && fer_ev;             // see R8
    assign ev[`CMOS_BIT_ACK_ERR]   = aer_ev && tx_obj == 4'(g);  // see R10
    // Software writes the value it wants kept; a fresh event still wins.
    wire [7:0] kept = (wr_stat && sel) ? SFR_WDATA : status_r[g];
    wire [7:0] status_nxt = kept | ev;                         // see R3
    wire       rx_here = rx_set && rx_obj == 4'(g);
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
        status_r[g] <= `CMOS_STATUS_RESET;
        ident_r[g]  <= 11'h000;
        dlc_r[g]    <= 4'h0;
      end else begin
        status_r[g] <= status_nxt;
        if (wr_high && sel) begin
          ident_r[g][10:3] <= SFR_WDATA;                       // see R11
        end else if (wr_low && sel) begin
          ident_r[g][2:0] <= SFR_WDATA[7:5];                   // see R12
        end else if (rx_here) begin
          ident_r[g] <= f.ident;
        end
        if (rx_here) begin
          dlc_r[g] <= f.data_length_code;                                   // see R14
        end else if (wr_dlc && sel) begin
          dlc_r[g] <= SFR_WDATA[3:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared state and outputs
  // ----------------------------------------------------------------
  wire [13:0] irq_vec;
  for (genvar g = 0; g < `CMOS_NUM_OBJ; g++) begin : g_irq
    assign irq_vec[g] = |(status_r[g] & `CMOS_IRQ_MASK);       // see R18
  end

  wire in_frame = !field_is(b.field, cmos_pkg::CMOS_FLD_IDLE);

  // A page change takes effect one cycle later, so software has to
  // select the object a cycle before it touches that object's registers.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cur_obj_r <= 4'h0;
    end else begin
      cur_obj_r <= (PAGE_OBJ < 4'(`CMOS_NUM_OBJ)) ? PAGE_OBJ : 4'h0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r   <= 8'h00;
      dlc_out_r <= 4'h0;
    end else begin
      rdata_r   <= SFR_RD ? rd_mux : rdata_r;
      dlc_out_r <= dlc_r[cur_obj_r];                           // see R14
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |irq_vec;                                       // see R18
    end
  end

  // The bit error is registered once more than the other error events,
  // which keeps the monitor compare off the flag update path.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      frame_tx_r <= 1'b0;
      bit_err_r  <= 1'b0;
      ack_seen_r <= 1'b0;
    end else begin
      frame_tx_r <= in_frame ? (frame_tx_r | b.tx_active) : 1'b0;
      bit_err_r  <= ber_ev;                                    // see R4
      ack_seen_r <= tx_set ? 1'b0 : (ack_seen_r | ack_ev);     // see R10
    end
  end

  assign SFR_RDATA = rdata_r;
  assign DLC_OUT   = dlc_out_r;
  assign IRQ       = irq_r;
endmodule : cmos_status

// ---- verification/cmos_status_props.sv ----
module cmos_status_props (
  input wire logic                  SYS_CLK,
  input wire logic                  RESETN,
  input wire logic [3:0]            PAGE_OBJ,
  input wire logic [7:0]            SFR_ADDR,
  input wire logic                  SFR_WR,
  input wire logic                  SFR_RD,
  input wire cmos_pkg::cmos_bit_t   BIT_IN,
  input wire cmos_pkg::cmos_frame_t FRAME_IN,
  input wire logic [7:0]            SFR_RDATA,
  input wire logic [3:0]            DLC_OUT,
  input wire logic                  IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // Bit errors land one cycle later than frame events, hence depth 3.
  wire ev = FRAME_IN.rx_done | FRAME_IN.tx_done | BIT_IN.bit_valid | SFR_WR;
  a_rx_irq: assert property (
    FRAME_IN.rx_done && |FRAME_IN.rx_hits |-> ##2 IRQ) else $error("rx no irq");
  a_tx_irq: assert property (
    FRAME_IN.tx_done && |FRAME_IN.tx_pend |-> ##2 IRQ) else $error("tx no irq");
  a_irq_hold: assert property (
    IRQ && !$past(SFR_WR) |=> IRQ) else $error("irq dropped");
  a_irq_cause: assert property (
    $rose(IRQ) |-> $past(ev, 2) || $past(ev, 3)) else $error("irq no cause");
  a_unmapped_rd: assert property (
    SFR_RD && SFR_ADDR == 8'h00 |=> SFR_RDATA == 8'h00) else $error("unmapped");
  a_tag_rsv: assert property (
    SFR_RD && SFR_ADDR == 8'hbd |=> SFR_RDATA[4:0] == 5'h00) else $error("rsv");
  a_rdata_stands: assert property (
    !SFR_RD |=> $stable(SFR_RDATA)) else $error("rdata moved");
  a_dlc_update: assert property (
    FRAME_IN.rx_done && FRAME_IN.rx_hits[0] && PAGE_OBJ == 4'h0
    && $past(PAGE_OBJ) == 4'h0 |-> ##2 DLC_OUT == $past(FRAME_IN.data_length_code, 2))
    else $error("dlc stale");
endmodule : cmos_status_props

// ---- verification/cmos_peer.sv ----
module cmos_peer (
  input  wire logic                  tx_level,
  input  wire cmos_pkg::cmos_field_t field,
  input  wire logic                  ack_en,
  input  wire logic                  jam,
  output logic                       rx_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wired-AND bus: any node driving dominant wins over recessive.
  assign rx_level = tx_level & ~jam &
    ~(ack_en && field == cmos_pkg::CMOS_FLD_ACK);
endmodule : cmos_peer

// ---- verification/can_msg_obj_status_and_std_id_tag_test.sv ----
module can_msg_obj_status_and_std_id_tag_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk, rst_n, wr, rd, bv, ta, tl, sv, cb, jam, ack;
  logic                  rxl, irq;
  logic [3:0]            pg, dlc_o, d, e;
  logic [7:0]            ad, wd, rdata;
  logic [10:0]           id;
  logic [13:0]           h;
  cmos_pkg::cmos_field_t fld;
  cmos_pkg::cmos_bit_t   bi;
  cmos_pkg::cmos_frame_t fr;
  int                    err_count, n_compared;
  cmos_pkg::cmos_field_t fq [4] = '{cmos_pkg::CMOS_FLD_CRCD,
    cmos_pkg::CMOS_FLD_ACKD, cmos_pkg::CMOS_FLD_EOF, cmos_pkg::CMOS_FLD_CTRL};
  logic [7:0]            ef [6] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h08, 8'h04};
  assign bi = {bv, ta, tl, rxl, fld, sv, cb};
  cmos_status u_cmos_status (.SYS_CLK(clk), .RESETN(rst_n), .PAGE_OBJ(pg),
    .SFR_ADDR(ad), .SFR_WDATA(wd), .SFR_WR(wr), .SFR_RD(rd), .BIT_IN(bi),
    .FRAME_IN(fr), .SFR_RDATA(rdata), .DLC_OUT(dlc_o), .IRQ(irq));
  cmos_peer u_cmos_peer (.tx_level(tl), .field(fld), .ack_en(ack),
    .jam(jam), .rx_level(rxl));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // --------
  // Tasks
  // --------
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask : cyc
  task automatic chk(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, v);
    ad = a;
    wd = v;
    wr = 1;
    cyc();
    wr = 0;
    cyc();
  endtask : wreg
  task automatic rreg(input logic [7:0] a, x);
    ad = a;
    rd = 1;
    cyc();
    rd = 0;
    chk(rdata, x);
    cyc();
  endtask : rreg
  task automatic sbit(input cmos_pkg::cmos_field_t f, input logic j, s, c);
    fld = f;
    jam = j;
    sv = s;
    cb = c;
    bv = 1;
    cyc();
    {bv, jam, sv, cb} = 4'h0;
    cyc();
  endtask : sbit
  task automatic frame(input logic r, input logic [13:0] m);
    fr = {r, ~r, r ? m : 14'h0, r ? 14'h0 : m, d, id};
    cyc();
    {fr.rx_done, fr.tx_done} = 2'b00;
    cyc(3);
  endtask : frame
  function automatic logic [3:0] low(input logic [13:0] m);
    low = 4'h0;
    for (int k = 13; k >= 0; k--) if (m[k]) low = 4'(k);
  endfunction : low
  function automatic logic [7:0] exp_tx(input int k);
    return {3'b010, k == 2, 3'h0, k == 1};
  endfunction : exp_tx
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    #(20000 * 50);
    err_count++;
    final_report();
  end
  initial begin
    {wr, rd, bv, ta, sv, cb, jam, ack, rst_n, d, id} = '0;
    {pg, ad, wd, fr, err_count, n_compared} = '0;
    tl = 1;
    fld = cmos_pkg::CMOS_FLD_IDLE;
    void'($urandom(85));
    cyc(6);
    rst_n = 1;
    foreach (ef[i]) rreg(i == 0 ? 8'hb2 : i == 1 ? 8'hbc :
                         i == 2 ? 8'hbd : 8'h00, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      id = 11'($urandom);
      d = 4'($urandom_range(8));
      e = i ? 4'($urandom_range(8)) : d;
      h = i ? 14'($urandom_range(16383, 1)) : 14'h1;
      pg = low(h);
      cyc();
      wreg(8'hb3, {4'h0, e});
      frame(1, h);
      chk({7'h0, irq}, 8'h01);
      chk({4'h0, dlc_o}, {4'h0, d});
      rreg(8'hb2, {d != e, 7'h20});
      rreg(8'hbc, id[10:3]);
      rreg(8'hbd, {id[2:0], 5'h00});
      wreg(8'hbc, ~id[10:3]);
      rreg(8'hbc, ~id[10:3]);
      wreg(8'hb2, 8'h00);
      chk({7'h0, irq}, 8'h00);
      if (h & (h - 14'h1)) begin
        pg = low(h & (h - 14'h1));
        cyc();
        rreg(8'hb2, 8'h00);
      end
    end
    $display("receive test done");
    {ta, pg, fr.tx_pend} = {1'b1, 4'h3, 14'h0018};
    for (int k = 0; k < 3; k++) begin
      ack = (k != 1);
      sbit(cmos_pkg::CMOS_FLD_ARB, 1, 0, 0);
      sbit(cmos_pkg::CMOS_FLD_CTRL, k == 2, 0, 0);
      sbit(cmos_pkg::CMOS_FLD_ACK, 0, 0, 0);
      sbit(cmos_pkg::CMOS_FLD_ERRF, 1, 0, 0);
      frame(0, 14'h0018);
      rreg(8'hb2, exp_tx(k));
      wreg(8'hb2, 8'h00);
    end
    $display("transmit test done");
    {ta, pg, fr} = {1'b0, 4'h5, 45'h0};
    fld = cmos_pkg::CMOS_FLD_IDLE;
    cyc();
    foreach (ef[i]) begin
      sbit(fq[i < 3 ? i : 3], i < 4, i == 4, i == 5);
      rreg(8'hb2, ef[i]);
      wreg(8'hb2, 8'h00);
    end
    $display("error test done");
    final_report();
  end
endmodule : can_msg_obj_status_and_std_id_tag_test
bind cmos_status cmos_status_props u_props (.*);
